// ### logic/qec_top.sv
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - the mode field selects off, 16-bit timer, disabled for 010/011, and x2/x4 decoding with index or match reset.
// - with phase swap set the phase inputs are exchanged before decoding.
// - the timer prescale field divides by 256, 64, 8 or 1 for 11, 10, 01, 00.
// - the prescaler acts only in timer mode and is bypassed in decoding modes.
// - index reset enable lets an index pulse clear the counter, only in modes 100 and 110.
// - timer clock source set counts rising edges of phase a, clear counts the system clock.
// - direction source set takes direction from phase b, clear from the count direction bit.
// - in decoding modes direction comes from quadrature decoding and direction source is ignored.
module qec_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    input wire logic idle_mode,
    output logic [15:0] position_count
);
    logic [15:0] encoder_control;
    logic [15:0] max_count_limit;
    logic count_direction;
    logic [7:0] prescale_cnt;
    logic tclk_q;
    logic idx_q;
    logic [2:0] operating_mode_select;
    logic phase_swap;
    logic pa;
    logic pb;
    logic dec_step;
    logic dec_up;
    logic quad_mode;
    logic timer_mode;
    logic running;
    logic idx_rise;
    logic tick_in;
    logic [7:0] prescale_max;
    logic timer_tick;
    logic enc_reset;
    logic enc_step;
    logic up_now;
    logic [15:0] next_position;
    logic bus_req;
    logic bus_wr;
    logic dir_wr;

    // one count up or down, wrapping at 16 bits
    function automatic logic [15:0] step_count(input logic [15:0] value, input logic up);
        step_count = up ? value + 16'h0001 : value - 16'h0001;
    endfunction : step_count

    assign operating_mode_select = encoder_control[qec_pkg::MODE_HI:qec_pkg::MODE_LO];
    assign phase_swap = encoder_control[qec_pkg::BIT_SWAP];

    assign pa = phase_swap ? phase_b_input : phase_a_input;
    assign pb = phase_swap ? phase_a_input : phase_b_input;

    always_comb begin
        quad_mode = 1'b0;
        timer_mode = 1'b0;
        case (qec_pkg::qec_mode_e'(operating_mode_select))
            qec_pkg::QEC_TIMER: timer_mode = 1'b1;
            qec_pkg::QEC_X2_INDEX, qec_pkg::QEC_X2_MATCH,
            qec_pkg::QEC_X4_INDEX, qec_pkg::QEC_X4_MATCH: quad_mode = 1'b1;
            default: begin
                quad_mode = 1'b0;
                timer_mode = 1'b0;
            end
        endcase
    end

    assign running = !(idle_mode && encoder_control[qec_pkg::BIT_IDLE_STOP]);

    qec_decoder u_dec (
        .clock(clock),
        .rst(rst),
        .phase_a(pa),
        .phase_b(pb),
        .x4(operating_mode_select[1]),
        .step(dec_step),
        .step_up(dec_up)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tclk_q <= 1'b0;
            idx_q <= 1'b0;
        end else begin
            tclk_q <= phase_a_input;
            idx_q <= index_input;
        end
    end

    assign idx_rise = index_input && !idx_q;

    // timer source: rising edge of phase a pin or every clock
    assign tick_in = encoder_control[qec_pkg::BIT_TCS] ? (phase_a_input && !tclk_q) : 1'b1;

    always_comb begin
        case (encoder_control[qec_pkg::PS_HI:qec_pkg::PS_LO])
            2'b11: prescale_max = qec_pkg::PRESCALE_256;
            2'b10: prescale_max = qec_pkg::PRESCALE_64;
            2'b01: prescale_max = qec_pkg::PRESCALE_8;
            default: prescale_max = qec_pkg::PRESCALE_1;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_cnt <= 8'h00;
        end else if (!timer_mode) begin
            prescale_cnt <= 8'h00;
        end else if (running && tick_in) begin
            if (prescale_cnt >= prescale_max) begin
                prescale_cnt <= 8'h00;
            end else begin
                prescale_cnt <= prescale_cnt + 8'h01;
            end
        end
    end

    assign timer_tick = timer_mode && running && tick_in && (prescale_cnt >= prescale_max);

    // index reset only in the index-reset modes (bit 0 of mode clear)
    assign enc_reset = quad_mode && running && !operating_mode_select[0]
        && encoder_control[qec_pkg::BIT_IDX_RST] && idx_rise;
    assign enc_step = quad_mode && running && dec_step;

    always_comb begin
        if (quad_mode) begin
            up_now = dec_up;
        end else if (encoder_control[qec_pkg::BIT_DIR_SRC]) begin
            up_now = phase_b_input;
        end else begin
            up_now = count_direction;
        end
    end

    always_comb begin
        next_position = position_count;
        if (enc_reset) begin
            next_position = qec_pkg::COUNT_RESET;
        end else if (enc_step) begin
            if (up_now) begin
                if (operating_mode_select[0] && position_count == max_count_limit) begin
                    next_position = qec_pkg::COUNT_RESET;
                end else begin
                    next_position = step_count(position_count, 1'b1);
                end
            end else if (operating_mode_select[0] && position_count == qec_pkg::COUNT_RESET) begin
                next_position = max_count_limit;
            end else begin
                next_position = step_count(position_count, 1'b0);
            end
        end else if (timer_tick) begin
            next_position = step_count(position_count, up_now);
        end
    end

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a write lands at the edge where the master sees ack high
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    // direction is writable when the mode being written is off, timer or unused (bit 10 clear)
    assign dir_wr = bus_wr && wb_adr_i == qec_pkg::ADDR_CONTROL && wb_sel_i[1] && !wb_dat_i[qec_pkg::MODE_HI];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            position_count <= qec_pkg::COUNT_RESET;
        end else if (bus_wr && wb_adr_i == qec_pkg::ADDR_POSITION && &wb_sel_i[1:0]) begin
            position_count <= wb_dat_i[15:0];
        end else begin
            position_count <= next_position;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            encoder_control <= qec_pkg::CONTROL_RESET;
            max_count_limit <= qec_pkg::MAXCOUNT_RESET;
        end else if (bus_wr) begin
            if (wb_adr_i == qec_pkg::ADDR_CONTROL) begin
                if (wb_sel_i[0]) begin
                    encoder_control[7:0] <= wb_dat_i[7:0] & qec_pkg::CONTROL_WMASK[7:0];
                end
                if (wb_sel_i[1]) begin
                    encoder_control[15:8] <= wb_dat_i[15:8] & qec_pkg::CONTROL_WMASK[15:8];
                end
            end
            if (wb_adr_i == qec_pkg::ADDR_MAXCOUNT) begin
                if (wb_sel_i[0]) begin
                    max_count_limit[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    max_count_limit[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // direction bit: written outside decoding modes, follows the decoded steps inside them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_direction <= 1'b0;
        end else if (dir_wr) begin
            count_direction <= wb_dat_i[qec_pkg::BIT_DIR];
        end else if (enc_step) begin
            count_direction <= dec_up;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    qec_pkg::ADDR_CONTROL: begin
                        wb_dat_o[15:0] <= encoder_control;
                        wb_dat_o[qec_pkg::BIT_INDEX] <= index_input;
                        wb_dat_o[qec_pkg::BIT_DIR] <= count_direction;
                    end
                    qec_pkg::ADDR_POSITION: wb_dat_o[15:0] <= position_count;
                    qec_pkg::ADDR_MAXCOUNT: wb_dat_o[15:0] <= max_count_limit;
                    qec_pkg::ADDR_STATUS: wb_dat_o[2:0] <= {running, timer_mode, quad_mode};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    index_reset_a: assert property (@(posedge clock) disable iff (rst)
        enc_reset && !bus_wr |=> position_count == qec_pkg::COUNT_RESET)
        else $error("index reset did not clear counter");

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    bus_ack_a: assert property (@(posedge clock) disable iff (rst)
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");

    idle_halt_a: assert property (@(posedge clock) disable iff (rst)
        idle_mode && encoder_control[qec_pkg::BIT_IDLE_STOP] && !bus_wr |=> $stable(position_count))
        else $error("counter moved while idle stopped");

    disabled_mode_a: assert property (@(posedge clock) disable iff (rst)
        operating_mode_select[2:1] == 2'b01 && !bus_wr |=> $stable(position_count))
        else $error("counter moved in unused mode");

    swap_path_a: assert property (@(posedge clock) disable iff (rst)
        phase_swap |-> pa == phase_b_input && pb == phase_a_input)
        else $error("phase swap not applied");

    no_prescale_a: assert property (@(posedge clock) disable iff (rst)
        quad_mode |-> !timer_tick ##1 prescale_cnt == 8'h00)
        else $error("prescaler active in decode mode");

    prescale_wrap_a: assert property (@(posedge clock) disable iff (rst)
        timer_mode && running && tick_in && prescale_cnt == prescale_max |=> prescale_cnt == 8'h00)
        else $error("prescaler did not wrap");

    dir_source_a: assert property (@(posedge clock) disable iff (rst)
        !quad_mode && encoder_control[qec_pkg::BIT_DIR_SRC] |-> up_now == phase_b_input)
        else $error("direction not taken from phase b");

    quad_dir_a: assert property (@(posedge clock) disable iff (rst)
        quad_mode |-> up_now == dec_up)
        else $error("decode direction ignored");

    ext_clock_a: assert property (@(posedge clock) disable iff (rst)
        timer_mode && encoder_control[qec_pkg::BIT_TCS] && !(phase_a_input && !tclk_q) |-> !timer_tick)
        else $error("timer ticked without phase a edge");

    sequence s_up_at_max;
        enc_step && up_now && operating_mode_select[0] && position_count == max_count_limit && !bus_wr;
    endsequence
    match_wrap_a: assert property (@(posedge clock) disable iff (rst)
        s_up_at_max |=> position_count == qec_pkg::COUNT_RESET)
        else $error("counter did not wrap at max count");

    match_no_index_a: assert property (@(posedge clock) disable iff (rst)
        quad_mode && operating_mode_select[0] && idx_rise && !dec_step && !bus_wr |=> $stable(position_count))
        else $error("index pulse acted in match mode");

    index_disabled_a: assert property (@(posedge clock) disable iff (rst)
        quad_mode && !encoder_control[qec_pkg::BIT_IDX_RST] && idx_rise && !dec_step && !bus_wr
        |=> $stable(position_count))
        else $error("index pulse acted while disabled");

    dir_track_a: assert property (@(posedge clock) disable iff (rst)
        enc_step && !dir_wr |=> count_direction == $past(dec_up))
        else $error("direction bit did not follow step");

    dir_write_a: assert property (@(posedge clock) disable iff (rst)
        dir_wr |=> count_direction == $past(wb_dat_i[qec_pkg::BIT_DIR]))
        else $error("direction bit write lost");
endmodule : qec_top

// ### common/qec_pkg.sv
package qec_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_POSITION = 4'h4;
    localparam logic [3:0] ADDR_MAXCOUNT = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    // control field positions
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_INDEX = 12;
    localparam int BIT_DIR = 11;
    localparam int MODE_HI = 10;
    localparam int MODE_LO = 8;
    localparam int BIT_SWAP = 7;
    localparam int PS_HI = 4;
    localparam int PS_LO = 3;
    localparam int BIT_IDX_RST = 2;
    localparam int BIT_TCS = 1;
    localparam int BIT_DIR_SRC = 0;
    // writable bits of the control word
    localparam logic [15:0] CONTROL_WMASK = 16'h2F9F;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MAXCOUNT_RESET = 16'hFFFF;
    localparam logic [7:0] PRESCALE_1 = 8'h00;
    localparam logic [7:0] PRESCALE_8 = 8'h07;
    localparam logic [7:0] PRESCALE_64 = 8'h3F;
    localparam logic [7:0] PRESCALE_256 = 8'hFF;

    typedef enum logic [2:0] {
        QEC_OFF = 3'b000,
        QEC_TIMER = 3'b001,
        QEC_UNUSED2 = 3'b010,
        QEC_UNUSED3 = 3'b011,
        QEC_X2_INDEX = 3'b100,
        QEC_X2_MATCH = 3'b101,
        QEC_X4_INDEX = 3'b110,
        QEC_X4_MATCH = 3'b111
    } qec_mode_e;
endpackage : qec_pkg

// ### logic/qec_decoder.sv
`timescale 1ns/10ps
// quadrature step detector: one step pulse and its direction per qualifying edge
module qec_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic x4,
    output logic step,
    output logic step_up
);
    logic a_q;
    logic b_q;
    logic a_chg;
    logic b_chg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= phase_a;
            b_q <= phase_b;
        end
    end

    assign a_chg = phase_a ^ a_q;
    assign b_chg = phase_b ^ b_q;

    // x2 counts edges of phase a only, x4 counts edges of both phases
    always_comb begin
        step = (a_chg && !b_chg) || (x4 && b_chg && !a_chg);
        if (a_chg) begin
            step_up = phase_a ^ phase_b;
        end else begin
            step_up = ~(phase_a ^ phase_b);
        end
    end
endmodule : qec_decoder

// ### bench/qec_encoder_model.sv
`timescale 1ns/10ps
// incremental encoder: phase a leads phase b when moving forward
module qec_encoder_model (
    input wire logic clock,
    output logic phase_a,
    output logic phase_b,
    output logic index
);
    logic [1:0] st = 2'b00;
    assign phase_a = st[1] ^ st[0];
    assign phase_b = st[1];
    initial index = 1'b0;
    // one gray step per call round, each state held hold+1 cycles
    task automatic move(input int n, input bit fwd, input int hold);
        repeat (n) begin
            @(posedge clock);
            st <= fwd ? st + 2'h1 : st - 2'h1;
            repeat (hold) @(posedge clock);
        end
    endtask : move
    task automatic set_index(input logic v);
        @(posedge clock);
        index <= v;
    endtask : set_index
endmodule : qec_encoder_model

// ### bench/test_qec_top.sv
`timescale 1ns/10ps
module test_qec_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_ack_o;
    logic pa;
    logic pb;
    logic idx;
    logic idle_mode = 1'b0;
    logic [15:0] position_count;
    logic [31:0] rd;
    logic [15:0] d;
    int n_errors = 0;
    int compares = 0;
    always #2 clock = ~clock;
    qec_top u_dut (.clock(clock), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(idx), .idle_mode(idle_mode),
        .position_count(position_count));
    qec_encoder_model u_enc (.clock(clock), .phase_a(pa), .phase_b(pb), .index(idx));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic [3:0] a, input logic w, input logic [15:0] v);
        int n;
        n = 0;
        @(posedge clock);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= {16'h0000, v};
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        rd = wb_dat_o;
        if (n >= 100) check(16'h0001, 16'h0000);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        wb(a, 1'b0, 16'h0000);
        check(rd[15:0] & m, exp);
    endtask : rdchk
    // position change over n cycles, sampled away from the active edge
    task automatic span(input int n);
        logic [15:0] p0;
        @(negedge clock);
        p0 = position_count;
        repeat (n) @(negedge clock);
        d = position_count - p0;
    endtask : span
    task automatic pulse_index();
        u_enc.set_index(1'b1);
        repeat (4) @(posedge clock);
        u_enc.set_index(1'b0);
    endtask : pulse_index
    task automatic t_reset();
        rdchk(qec_pkg::ADDR_CONTROL, 16'hEFFF, 16'h0000);
        rdchk(qec_pkg::ADDR_MAXCOUNT, 16'hFFFF, 16'hFFFF);
        rdchk(4'h2, 16'hFFFF, 16'h0000);
        u_enc.set_index(1'b1);
        rdchk(qec_pkg::ADDR_CONTROL, 16'h1000, 16'h1000);
        u_enc.set_index(1'b0);
        rdchk(qec_pkg::ADDR_CONTROL, 16'h1000, 16'h0000);
    endtask : t_reset
    task automatic t_x4();
        wb(qec_pkg::ADDR_MAXCOUNT, 1'b1, 16'h0005);
        wb(qec_pkg::ADDR_POSITION, 1'b1, 16'h0000);
        // prescale 11 and direction source set must both be ignored here
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0719);
        u_enc.move(8, 1'b1, 3);
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0002);
        rdchk(qec_pkg::ADDR_STATUS, 16'h0007, 16'h0005);
        rdchk(qec_pkg::ADDR_CONTROL, 16'h0800, 16'h0800);
        u_enc.move(3, 1'b0, 3);
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0005);
        rdchk(qec_pkg::ADDR_CONTROL, 16'h0800, 16'h0000);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0500);
        u_enc.move(4, 1'b1, 3);
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0001);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0504);
        pulse_index();
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0001);
    endtask : t_x4
    task automatic t_x2();
        wb(qec_pkg::ADDR_MAXCOUNT, 1'b1, 16'hFFFF);
        wb(qec_pkg::ADDR_POSITION, 1'b1, 16'h0000);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0400);
        u_enc.move(4, 1'b1, 3);
        pulse_index();
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0002);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0604);
        pulse_index();
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'h0000);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0484);
        u_enc.move(4, 1'b1, 3);
        rdchk(qec_pkg::ADDR_POSITION, 16'hFFFF, 16'hFFFE);
    endtask : t_x2
    task automatic t_timer();
        int sh[4] = '{0, 3, 6, 8};
        logic [15:0] p0;
        for (int i = 0; i < 4; i++) begin
            wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0900 | 16'(i << 3));
            span(512);
            check(d, 16'(512 >> sh[i]));
        end
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0100);
        span(64);
        check(d, 16'hFFC0);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0101);
        for (int i = 0; i < 2; i++) begin
            u_enc.move(2, 1'b1, 0);
            span(64);
            check(d, pb ? 16'h0040 : 16'hFFC0);
        end
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0902);
        @(negedge clock);
        p0 = position_count;
        u_enc.move(20, 1'b1, 3);
        repeat (4) @(negedge clock);
        check(position_count - p0, 16'h0005);
    endtask : t_timer
    task automatic t_idle_off();
        logic [2:0] m[3] = '{3'h0, 3'h2, 3'h3};
        @(posedge clock);
        idle_mode <= 1'b1;
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h2900);
        span(64);
        check(d, 16'h0000);
        rdchk(qec_pkg::ADDR_STATUS, 16'h0007, 16'h0002);
        wb(qec_pkg::ADDR_CONTROL, 1'b1, 16'h0900);
        span(64);
        check(d, 16'h0040);
        @(posedge clock);
        idle_mode <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wb(qec_pkg::ADDR_CONTROL, 1'b1, {5'h01, m[i], 8'h00});
            span(64);
            check(d, 16'h0000);
        end
    endtask : t_idle_off
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_x4();
        t_x2();
        t_timer();
        t_idle_off();
        print_verdict();
    end
endmodule : test_qec_top
